// ### call_mode_asserts.sv
// Purpose: port assertions for call_mode_core
// Assumes: one SYS_CLK domain, RESETN synchronous low; Notes: bound below
`timescale 1ns/1ps
module call_mode_asserts import call_mode_pkg::*; (
    input logic SYS_CLK,
    input logic RESETN,
    input req_t REQ,
    input logic [11:0] PC,
    input logic [3:0] STACK_BANK_SELECT,
    input logic COMPACT_CALL_MODE,
    input logic VEC_FETCH,
    input logic [11:0] FETCH_ADDR,
    input logic [11:0] NEXT_PC,
    input logic PC_LOAD,
    input logic [1:0] STACK_BYTES,
    input logic STACK_PUSH,
    input logic STACK_POP,
    input logic [2:0] MACHINE_CYCLES,
    input logic ILLEGAL_OP
);
    op_t o;
    logic [1:0] hold_q, hold_d, nb;
    // hold_q counts the vector-fetch cycles in which requests are dropped
    always_comb begin
        o = hold_q == 2'h0 ? REQ.op : OP_NONE;
        nb = COMPACT_CALL_MODE ? 2'h2 : 2'h3;
        hold_d = o == OP_IRQ && REQ.irq_index <= 3'h5 ? 2'h1 : hold_q - {1'b0, hold_q != 2'h0};
    end
    always_ff @(posedge SYS_CLK) hold_q <= RESETN ? hold_d : 2'h2;
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESETN);
    sequence vec_pair(logic [11:0] a);
        VEC_FETCH && FETCH_ADDR == a ##1 VEC_FETCH && FETCH_ADDR == $past(FETCH_ADDR) + 12'h001;
    endsequence
    AST_RST: assert property (RESETN && !$past(RESETN) |=> vec_pair(12'h000))
        else $error("reset vector");
    AST_WR: assert property (o == OP_SEL_WR |=> STACK_BANK_SELECT == $past(REQ.nibble))
        else $error("nibble write");
    AST_PUSH: assert property (o inside {OP_CALL, OP_FCALL}
        |=> STACK_PUSH && STACK_BYTES == $past(nb)) else $error("push size");
    AST_CYC: assert property (o inside {OP_CALL, OP_FCALL}
        |=> MACHINE_CYCLES == {1'b0, $past(nb)} + 3'($past(o) == OP_CALL)) else $error("cycles");
    AST_EXT: assert property (o inside {OP_XCALL, OP_XBRANCH} && COMPACT_CALL_MODE
        |=> ILLEGAL_OP && !STACK_PUSH && !PC_LOAD) else $error("extended op");
    AST_PCL: assert property (o inside {OP_LOW_DE, OP_LOW_XA}
        |=> PC_LOAD && NEXT_PC == {$past(PC[11:8]), $past(REQ.pair)}) else $error("pc low");
    AST_IRQ: assert property (o == OP_IRQ && REQ.irq_index <= 3'h5
        |=> vec_pair({8'h00, $past(REQ.irq_index), 1'b0} + 12'h002)) else $error("irq vector");
    AST_TBL: assert property (o == OP_TABLE
        |=> FETCH_ADDR == {5'h00, $past(REQ.target[5:0]), 1'b0} + 12'h020) else $error("table");
endmodule
bind call_mode_core call_mode_asserts chk_u (.*);

// ### call_mode_core.sv
// Purpose: call-mode selection, stack cost and program-memory vector map
// Assumes: a sequencer presents one decoded request per cycle, REQ.op OP_NONE when idle
// Notes: all outputs registered
`timescale 1ns/1ps
`include "call_mode_defines.svh"
module call_mode_core
    import call_mode_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RESETN,
    input wire req_t REQ,
    input wire logic [11:0] PC,
    output logic [3:0] STACK_BANK_SELECT,
    output logic COMPACT_CALL_MODE,
    output logic VEC_FETCH,
    output logic [11:0] FETCH_ADDR,
    output logic [11:0] NEXT_PC,
    output logic PC_LOAD,
    output logic [1:0] STACK_BYTES,
    output logic STACK_PUSH,
    output logic STACK_POP,
    output logic [2:0] MACHINE_CYCLES,
    output logic ILLEGAL_OP
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    state_t state_q, state_d;
    logic [3:0] sel_q, sel_d;
    logic vec_fetch_q, vec_fetch_d;
    logic [11:0] fetch_addr_q, fetch_addr_d;
    logic [11:0] next_pc_q, next_pc_d;
    logic pc_load_q, pc_load_d;
    logic [1:0] bytes_q, bytes_d;
    logic push_q, push_d;
    logic pop_q, pop_d;
    logic [2:0] cyc_q, cyc_d;
    logic illegal_q, illegal_d;
    logic compact;
    logic [1:0] dec_bytes;
    logic [2:0] dec_cycles;
    logic dec_legal;

    // selector bit: 1 compact, 0 extended
    assign compact = sel_q[`MODE_SEL_BIT];

    // per-mode byte and cycle costs come from the lookup
    call_mode_decode u_decode (
        .compact(compact),
        .op(REQ.op),
        .stack_bytes(dec_bytes),
        .cycles(dec_cycles),
        .legal(dec_legal)
    );

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        vec_fetch_d = 1'b0;
        fetch_addr_d = fetch_addr_q;
        next_pc_d = next_pc_q;
        pc_load_d = 1'b0;
        bytes_d = 2'h0;
        push_d = 1'b0;
        pop_d = 1'b0;
        cyc_d = 3'h1;
        illegal_d = 1'b0;
        case (state_q)
            ST_RESET: begin
                // reset vector occupies two bytes, first byte here
                vec_fetch_d = 1'b1;
                fetch_addr_d = `RESET_VEC_ADDR;
                state_d = ST_VEC;
            end
            ST_VEC: begin
                // second vector byte follows the first
                vec_fetch_d = 1'b1;
                fetch_addr_d = fetch_addr_q + 12'h001;
                state_d = ST_RUN;
            end
            ST_RUN: begin
                // requests are taken only here; ST_RESET and ST_VEC drop them
                cyc_d = dec_cycles;
                case (REQ.op)
                    OP_CALL, OP_FCALL, OP_XCALL: begin
                        if (dec_legal) begin
                            push_d = 1'b1;
                            bytes_d = dec_bytes;
                            next_pc_d = REQ.target;
                            pc_load_d = 1'b1;
                        end else begin
                            illegal_d = 1'b1;
                        end
                    end
                    OP_XBRANCH: begin
                        if (dec_legal) begin
                            next_pc_d = REQ.target;
                            pc_load_d = 1'b1;
                        end else begin
                            illegal_d = 1'b1;
                        end
                    end
                    OP_RET: begin
                        pop_d = 1'b1;
                        bytes_d = dec_bytes;
                    end
                    OP_LOW_DE, OP_LOW_XA: begin
                        next_pc_d = {PC[11:8], REQ.pair};
                        pc_load_d = 1'b1;
                    end
                    OP_TABLE: begin
                        // one table entry is two bytes
                        vec_fetch_d = 1'b1;
                        fetch_addr_d = `TBL_BASE + {5'h00, REQ.target[5:0], 1'b0};
                        if (fetch_addr_d > `TBL_LAST) begin
                            illegal_d = 1'b1;
                        end
                    end
                    OP_SEL_WR: begin
                        // the register itself is written in its own group below
                    end
                    OP_IRQ: begin
                        vec_fetch_d = 1'b1;
                        fetch_addr_d = `IRQ_VEC_BASE + {8'h00, REQ.irq_index, 1'b0};
                        if (fetch_addr_d > `IRQ_VEC_LAST) begin
                            // out-of-range index: no fetch, address output keeps its value
                            illegal_d = 1'b1;
                            vec_fetch_d = 1'b0;
                            fetch_addr_d = fetch_addr_q;
                        end else begin
                            state_d = ST_VEC;
                        end
                    end
                    default: begin
                        cyc_d = 3'h1;
                    end
                endcase
            end
            default: begin
                state_d = ST_RESET;
            end
        endcase
    end

    // ------------------------------------------------------------
    // stack bank select register
    // ------------------------------------------------------------
    always_comb begin
        sel_d = sel_q;
        // one nibble write replaces selector and bank bits together
        if (state_q == ST_RUN && REQ.op == OP_SEL_WR) begin
            sel_d = REQ.nibble;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            sel_q <= `STACK_SEL_RESET;
        end else begin
            sel_q <= sel_d;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            state_q <= ST_RESET;
            vec_fetch_q <= 1'b0;
            fetch_addr_q <= 12'h000;
            next_pc_q <= 12'h000;
            pc_load_q <= 1'b0;
            bytes_q <= 2'h0;
            push_q <= 1'b0;
            pop_q <= 1'b0;
            cyc_q <= 3'h1;
            illegal_q <= 1'b0;
        end else begin
            state_q <= state_d;
            vec_fetch_q <= vec_fetch_d;
            fetch_addr_q <= fetch_addr_d;
            next_pc_q <= next_pc_d;
            pc_load_q <= pc_load_d;
            bytes_q <= bytes_d;
            push_q <= push_d;
            pop_q <= pop_d;
            cyc_q <= cyc_d;
            illegal_q <= illegal_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign STACK_BANK_SELECT = sel_q;
    assign COMPACT_CALL_MODE = sel_q[`MODE_SEL_BIT];
    assign VEC_FETCH = vec_fetch_q;
    assign FETCH_ADDR = fetch_addr_q;
    assign NEXT_PC = next_pc_q;
    assign PC_LOAD = pc_load_q;
    assign STACK_BYTES = bytes_q;
    assign STACK_PUSH = push_q;
    assign STACK_POP = pop_q;
    assign MACHINE_CYCLES = cyc_q;
    assign ILLEGAL_OP = illegal_q;
endmodule

// ### call_mode_decode.sv
// Purpose: per-mode cost lookup for calls and returns
// Assumes: compact is the selector set to 1
// Notes: purely combinational
`timescale 1ns/1ps
`include "call_mode_defines.svh"
module call_mode_decode
    import call_mode_pkg::*;
(
    input wire logic compact,
    input wire op_t op,
    output logic [1:0] stack_bytes,
    output logic [2:0] cycles,
    output logic legal
);
    always_comb begin
        stack_bytes = 2'h0;
        cycles = 3'h1;
        legal = 1'b1;
        case (op)
            OP_CALL: begin
                stack_bytes = compact ? `PUSH_COMPACT : `PUSH_EXTENDED;
                cycles = compact ? `CALL_CYC_COMPACT : `CALL_CYC_EXTENDED;
            end
            OP_FCALL: begin
                stack_bytes = compact ? `PUSH_COMPACT : `PUSH_EXTENDED;
                cycles = compact ? `FCALL_CYC_COMPACT : `FCALL_CYC_EXTENDED;
            end
            OP_XCALL: begin
                legal = ~compact;
                stack_bytes = legal ? `PUSH_EXTENDED : 2'h0;
                cycles = `CALL_CYC_EXTENDED;
            end
            OP_XBRANCH: begin
                legal = ~compact;
            end
            OP_RET: begin
                stack_bytes = compact ? `PUSH_COMPACT : `PUSH_EXTENDED;
            end
            default: begin
                legal = 1'b1;
            end
        endcase
    end
endmodule

// ### call_mode_defines.svh
// Purpose: constants for the call-mode and vector-map block
// Assumes: 12-bit program counter, 4-bit data nibbles
// Notes: definitions only
`ifndef CALL_MODE_DEFINES_SVH
`define CALL_MODE_DEFINES_SVH
`define MODE_SEL_BIT 3
`define STACK_SEL_RESET 4'h8
`define RESET_VEC_ADDR 12'h000
`define IRQ_VEC_BASE 12'h002
`define IRQ_VEC_LAST 12'h00D
`define TBL_BASE 12'h020
`define TBL_LAST 12'h07F
`define PUSH_COMPACT 2'h2
`define PUSH_EXTENDED 2'h3
`define CALL_CYC_COMPACT 3'h3
`define CALL_CYC_EXTENDED 3'h4
`define FCALL_CYC_COMPACT 3'h2
`define FCALL_CYC_EXTENDED 3'h3
`endif

// ### call_mode_pkg.sv
// Purpose: types shared by the call-mode block
// Assumes: nothing
// Notes: constants live in call_mode_defines.svh
package call_mode_pkg;
    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_CALL = 4'h1,
        OP_FCALL = 4'h2,
        OP_XCALL = 4'h3,
        OP_XBRANCH = 4'h4,
        OP_RET = 4'h5,
        OP_LOW_DE = 4'h6,
        OP_LOW_XA = 4'h7,
        OP_TABLE = 4'h8,
        OP_SEL_WR = 4'h9,
        OP_IRQ = 4'hA
    } op_t;
    typedef struct packed {
        op_t op;
        logic [11:0] target;
        logic [7:0] pair;
        logic [3:0] nibble;
        logic [2:0] irq_index;
    } req_t;
    typedef enum logic [2:0] {
        ST_RESET = 3'b001,
        ST_RUN = 3'b010,
        ST_VEC = 3'b100
    } state_t;
endpackage

// ### stack_model.sv
// Purpose: stack RAM, tracks bytes held
// Assumes: push and pop pulse one cycle; Notes: no data kept
`timescale 1ns/1ps
module stack_model (
    input logic SYS_CLK,
    input logic RESETN,
    input logic STACK_PUSH,
    input logic STACK_POP,
    input logic [1:0] STACK_BYTES,
    output int depth_q
);
    int n;
    assign n = int'(STACK_BYTES);
    always_ff @(posedge SYS_CLK) begin
        depth_q <= RESETN ? depth_q + (STACK_PUSH ? n : 0) - (STACK_POP ? n : 0) : 0;
    end
endmodule

// ### tb_top.sv
// Purpose: directed test of call_mode_core
// Assumes: inputs change at the falling edge; Notes: stack_model tracks depth
`timescale 1ns/1ps
module tb_top import call_mode_pkg::*; ;
    logic SYS_CLK = 1'b0, RESETN;
    req_t REQ;
    logic [11:0] PC = 12'hABC;
    logic [3:0] STACK_BANK_SELECT;
    logic COMPACT_CALL_MODE, VEC_FETCH, PC_LOAD, STACK_PUSH, STACK_POP, ILLEGAL_OP;
    logic [11:0] FETCH_ADDR, NEXT_PC, nb;
    logic [1:0] STACK_BYTES;
    logic [2:0] MACHINE_CYCLES;
    int depth_q, err_count = 0, compares = 0;
    call_mode_core dut_u (.*);
    stack_model mem_u (.*);
    initial forever #2.5 SYS_CLK = ~SYS_CLK;
    task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic op(input op_t o, input logic [11:0] t, input logic [7:0] p);
        REQ = '{o, t, p, t[3:0], t[2:0]};
        @(negedge SYS_CLK);
    endtask
    task automatic idle;
        REQ.op = OP_NONE;
        @(negedge SYS_CLK);
    endtask
    task automatic reset_run(input int n);
        REQ = '0;
        RESETN = 1'b0;
        repeat (n) @(negedge SYS_CLK);
        RESETN = 1'b1;
        @(negedge SYS_CLK);
        chk("bank_sel", 12'h008, {8'h00, STACK_BANK_SELECT});
        chk("vec", 12'h000, VEC_FETCH ? FETCH_ADDR : 12'hFFF);
        chk("depth0", 12'h000, depth_q[11:0]);
        @(negedge SYS_CLK);
        chk("vec2", 12'h001, VEC_FETCH ? FETCH_ADDR : 12'hFFF);
    endtask
    task automatic test_done;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (1000) @(posedge SYS_CLK);
        err_count++;
        test_done();
    end
    initial begin
        reset_run(20);
        for (int i = 1; i >= 0; i--) begin
            nb = i[0] ? 12'h002 : 12'h003;
            PC = i[0] ? 12'hABC : 12'h61C;
            op(OP_SEL_WR, {8'h00, i[0], 3'h0}, 8'h00);
            chk("mode", {11'h000, i[0]}, {11'h000, COMPACT_CALL_MODE});
            op(OP_CALL, 12'h5A3, 8'h00);
            chk("call", nb + 12'h001, {9'h000, MACHINE_CYCLES});
            op(OP_FCALL, 12'h10F, 8'h00);
            chk("fcall", nb, {9'h000, MACHINE_CYCLES});
            chk("push", nb, depth_q[11:0]);
            op(OP_RET, 12'h000, 8'h00);
            op(OP_RET, 12'h000, 8'h00);
            chk("pop", nb, STACK_POP ? {10'h000, STACK_BYTES} : 12'hFFF);
            op(i[0] ? OP_XCALL : OP_XBRANCH, 12'h7F0, 8'h00);
            chk("depth", 12'h000, depth_q[11:0]);
            chk("ill", {11'h000, i[0]}, {11'h000, ILLEGAL_OP});
            op(i[0] ? OP_LOW_DE : OP_LOW_XA, 12'h000, 8'h3D);
            chk("pc_low", {i[0] ? 4'hA : 4'h6, 8'h3D}, PC_LOAD ? NEXT_PC : 12'hFFF);
            op(i[0] ? OP_XBRANCH : OP_XCALL, 12'h7F0, 8'h00);
            chk("ill2", {11'h000, i[0]}, {11'h000, ILLEGAL_OP});
            chk("xpush", i[0] ? 12'h000 : 12'h003, {10'h000, STACK_BYTES});
        end
        reset_run(2);
        for (int i = 0; i < 7; i++) begin
            nb = i < 6 ? 12'(2 + 2 * i) : 12'hFFF;
            op(OP_IRQ, 12'(i), 8'h00);
            chk("irq", nb, VEC_FETCH ? FETCH_ADDR : 12'hFFF);
            idle();
        end
        op(OP_TABLE, 12'h02F, 8'h00);
        chk("tbl", 12'h07E, VEC_FETCH ? FETCH_ADDR : 12'hFFF);
        op(OP_TABLE, 12'h030, 8'h00);
        chk("tbl_ill", 12'h001, {11'h000, ILLEGAL_OP});
        test_done();
    end
endmodule
